// >>> include/drive_presence_status_indicator_consts.svh
// Constants for the drive presence and status indicator block
`ifndef DRIVE_PRESENCE_STATUS_INDICATOR_CONSTS_SVH
`define DRIVE_PRESENCE_STATUS_INDICATOR_CONSTS_SVH

// ********************************
// Register map (byte addresses)
// ********************************
`define REG_RERUN_OFS 8'h00
`define REG_REQUIRED_OFS 8'h04
`define REG_STATUS_OFS 8'h08
`define REG_NAME_OFS 8'h0C
`define RERUN_CODE 32'hFFFFFFFC
`define REQUIRED_RESET 8'h00
`define STAT_BUSY_BIT 8
`define STAT_DONE_BIT 9
`define NAME_MODE_LSB 16
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

// ********************************
// Drive configuration values
// ********************************
`define DRIVE_LINK_ADDR 16'h0001
`define LAST_PORT 3'd7
`define MCT_BAUD0 16'h0040
`define MCT_BAUD1 16'h0020
`define MCT_BAUD2 16'h0010
`define MCT_BAUD3 16'h0008

// ********************************
// Timing
// ********************************
`define CLK_PERIOD_NS 10
`define TICK_TIME_NS 50000000
`define TICK_CYCLES (`TICK_TIME_NS / `CLK_PERIOD_NS)
`define FLASH5_LAST 1'b1
`define FLASH2_LAST 3'd4
`define IDENT_TIME_NS 64'd3000000000
`define IDENT_TICKS (`IDENT_TIME_NS / `TICK_TIME_NS)
`define SETTLE_LAST 2'd3

`endif

// >>> include/drive_status_pkg.sv
// Types shared by the drive presence and status indicator block
package drive_status_pkg;
  // Presence test sequencer, Gray coded along idle-issue-wait-done
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ISSUE = 2'b01,
    ST_WAIT = 2'b11,
    ST_DONE = 2'b10
  } seq_state_t;
  // Configuration steps sent to one drive port
  typedef enum logic [1:0] {OP_PROBE, OP_BAUD, OP_MCT, OP_ADDR} drive_op_t;
  // Where the station name comes from
  typedef enum logic [1:0] {NAME_CONTROLLER, NAME_SWITCH, NAME_STORED} name_mode_t;
  typedef logic [1:0] baud_code_t;
  // Request towards the serial-link engine
  typedef struct packed {
    drive_op_t op;
    logic [2:0] port;
    logic [15:0] data;
  } drive_cmd_t;
  // Answer from the serial-link engine
  typedef struct packed {
    logic valid;
    logic ok;
  } drive_resp_t;
  // One network port as seen from the PHY logic
  typedef struct packed {
    logic link;
    logic activity;
  } eth_port_t;
  // Red and green halves of a two-colour lamp
  typedef struct packed {
    logic red;
    logic green;
  } bicolor_t;
  // Station name source and number
  typedef struct packed {
    name_mode_t mode;
    logic [15:0] number;
  } station_name_t;
endpackage : drive_status_pkg

// >>> design/drive_presence_status_indicator.sv
// Start-up presence test, lamp driver and station naming for a drive hub
//
// Implementation choices: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ns
`include "drive_presence_status_indicator_consts.svh"

module drive_presence_status_indicator #(
  parameter int TICK_CYCLES = `TICK_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic awvalid,
  output logic awready,
  input wire logic [7:0] awaddr,
  // AXI4-Lite write data
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  // AXI4-Lite write response
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  // AXI4-Lite read address
  input wire logic arvalid,
  output logic arready,
  input wire logic [7:0] araddr,
  // AXI4-Lite read data
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  // Serial-link engine requests and answers
  output logic cmd_valid,
  input wire logic cmd_ready,
  output drive_status_pkg::drive_cmd_t cmd,
  input wire drive_status_pkg::drive_resp_t resp,
  // Non-volatile store contents
  input wire logic [7:0] nv_required,
  input wire drive_status_pkg::baud_code_t [7:0] nv_baud,
  input wire logic [15:0] nv_address,
  // Drive health from the serial-link engine
  input wire logic [7:0] comm_err,
  input wire logic [7:0] drive_err,
  // Network state from the fieldbus stack
  input wire drive_status_pkg::eth_port_t first_network_port,
  input wire drive_status_pkg::eth_port_t second_network_port,
  input wire logic net_connected,
  input wire logic data_exchange,
  input wire logic identify_req,
  input wire logic watchdog_timeout,
  input wire logic system_fault,
  input wire logic diag_pending,
  // Front panel switches (asynchronous pins)
  input wire logic [7:0] address_switch,
  input wire logic [3:0] drive_selector_switch,
  // Lamps
  output logic [1:0] link_lamp,
  output logic [1:0] activity_lamp,
  output logic network_fault_lamp,
  output logic status_fault_lamp,
  output drive_status_pkg::bicolor_t serial_lamp,
  // Drive run permission and station name
  output logic [7:0] run_enable,
  output logic [7:0] required_flags,
  output drive_status_pkg::station_name_t station_name
);
  import drive_status_pkg::*;

  // ********************************
  // Switch synchronisers
  // ********************************
  logic [7:0] addr_sw_meta_reg; // First stage, read only by second stage
  logic [7:0] addr_sw_reg; // Stable address switch value
  logic [3:0] sel_meta_reg; // First stage of selector
  logic [3:0] sel_reg; // Stable selector value

  // Two flops per pin, the switches are asynchronous to aclk
  always_ff @(posedge aclk) begin
    addr_sw_meta_reg <= address_switch;
    addr_sw_reg <= addr_sw_meta_reg;
    sel_meta_reg <= drive_selector_switch;
    sel_reg <= sel_meta_reg;
  end

  // ********************************
  // Common timebase
  // ********************************
  logic [31:0] tick_cnt_reg; // Cycles inside one tick
  logic tick; // One cycle every tick
  logic ph10_reg; // 10 Hz square wave
  logic ph5_cnt_reg; // Ticks inside a 5 Hz half period
  logic ph5_reg; // 5 Hz square wave
  logic [2:0] ph2_cnt_reg; // Ticks inside a 2 Hz half period
  logic ph2_reg; // 2 Hz square wave

  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // Every flash rate divides this one tick so lamps stay in phase
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_reg <= 32'h0;
      ph10_reg <= 1'b0;
      ph5_cnt_reg <= 1'b0;
      ph5_reg <= 1'b0;
      ph2_cnt_reg <= 3'h0;
      ph2_reg <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      if (tick) begin
        ph10_reg <= ~ph10_reg;
        ph5_cnt_reg <= ~ph5_cnt_reg;
        if (ph5_cnt_reg == `FLASH5_LAST) begin
          ph5_reg <= ~ph5_reg;
        end
        ph2_cnt_reg <= (ph2_cnt_reg == `FLASH2_LAST) ? 3'h0 : ph2_cnt_reg + 3'h1;
        if (ph2_cnt_reg == `FLASH2_LAST) begin
          ph2_reg <= ~ph2_reg;
        end
      end
    end
  end

  // ********************************
  // AXI4-Lite slave
  // ********************************
  logic aw_held_reg; // Write address taken, waiting for data
  logic [7:0] aw_addr_reg; // Held write address
  logic w_held_reg; // Write data taken, waiting for address
  logic [31:0] w_data_reg; // Held write data
  logic [3:0] w_strb_reg; // Held byte strobes
  logic bvalid_reg; // Write response pending
  logic [1:0] bresp_reg; // Write response code
  logic rvalid_reg; // Read data pending
  logic [31:0] rdata_reg; // Read data
  logic [1:0] rresp_reg; // Read response code
  logic wr_fire; // Both halves present, perform the write
  logic wr_is_rerun; // Write hits the rerun register
  logic wr_is_req; // Write hits the required-flag register
  logic wr_mapped; // Write hits any register
  logic rd_fire; // Read address accepted
  logic [31:0] rd_value; // Selected read value
  logic rd_mapped; // Read hits any register
  logic rerun_req; // Rerun value written with all lanes

  // New address or data is taken only while no response is pending
  assign awready = ~aw_held_reg & ~bvalid_reg;
  assign wready = ~w_held_reg & ~bvalid_reg;
  assign arready = ~rvalid_reg;
  assign bvalid = bvalid_reg;
  assign bresp = bresp_reg;
  assign rvalid = rvalid_reg;
  assign rdata = rdata_reg;
  assign rresp = rresp_reg;
  assign wr_fire = aw_held_reg & w_held_reg & ~bvalid_reg;
  assign rd_fire = arvalid & ~rvalid_reg;

  // Write decode
  assign wr_is_rerun = (aw_addr_reg == `REG_RERUN_OFS);
  assign wr_is_req = (aw_addr_reg == `REG_REQUIRED_OFS);
  assign wr_mapped = wr_is_rerun | wr_is_req | (aw_addr_reg == `REG_STATUS_OFS) |
                     (aw_addr_reg == `REG_NAME_OFS);
  // A partial write cannot form the full -4 value, so it is ignored
  assign rerun_req = wr_fire & wr_is_rerun & (w_strb_reg == 4'hF) &
                     (w_data_reg == `RERUN_CODE);

  // Hold each write half until its partner arrives, then answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= {awaddr[7:2], 2'b00};
      end
      if (wvalid && wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= wdata;
        w_strb_reg <= wstrb;
      end
      if (wr_fire) begin
        aw_held_reg <= 1'b0;
        w_held_reg <= 1'b0;
        bvalid_reg <= 1'b1;
        bresp_reg <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
      end else if (bvalid_reg && bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ********************************
  // Presence test sequencer
  // ********************************
  seq_state_t state_reg; // Sequencer state
  drive_op_t op_reg; // Step on the current port
  logic [2:0] port_reg; // Port under test
  logic [7:0] found_reg; // Ports where a drive answered
  logic [7:0] required_reg; // Drives released for run commands
  logic start_pending_reg; // A test is owed
  logic [15:0] mct_value; // Timeout for the stored speed
  logic last_step; // Current port is finished
  logic busy; // Test running

  assign busy = (state_reg == ST_ISSUE) | (state_reg == ST_WAIT);
  // A port ends after a failed probe or after the address step
  assign last_step = (op_reg == OP_ADDR) | ((op_reg == OP_PROBE) & ~resp.ok);

  // Completion timeout that goes with each stored speed
  always_comb begin
    case (nv_baud[port_reg])
      2'd0: mct_value = `MCT_BAUD0;
      2'd1: mct_value = `MCT_BAUD1;
      2'd2: mct_value = `MCT_BAUD2;
      default: mct_value = `MCT_BAUD3;
    endcase
  end

  // Request payload for the current step
  always_comb begin
    cmd.op = op_reg;
    cmd.port = port_reg;
    case (op_reg)
      OP_BAUD: cmd.data = {14'h0, nv_baud[port_reg]};
      OP_MCT: cmd.data = mct_value;
      OP_ADDR: cmd.data = `DRIVE_LINK_ADDR;
      default: cmd.data = 16'h0;
    endcase
  end
  assign cmd_valid = (state_reg == ST_ISSUE);

  // Walk every port: probe, then speed, timeout and address if found
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= ST_IDLE;
      op_reg <= OP_PROBE;
      port_reg <= 3'h0;
      found_reg <= 8'h00;
      required_reg <= `REQUIRED_RESET;
      start_pending_reg <= 1'b1;
    end else begin
      if (rerun_req) begin
        start_pending_reg <= 1'b1;
      end
      if (wr_fire && wr_is_req && w_strb_reg[0]) begin
        required_reg <= w_data_reg[7:0];
      end
      case (state_reg)
        ST_IDLE, ST_DONE: begin
          if (start_pending_reg) begin
            // A rerun request landing now is kept for the next round
            start_pending_reg <= rerun_req;
            required_reg <= nv_required;
            found_reg <= 8'h00;
            port_reg <= 3'h0;
            op_reg <= OP_PROBE;
            state_reg <= ST_ISSUE;
          end
        end
        ST_ISSUE: begin
          if (cmd_ready) begin
            state_reg <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (resp.valid) begin
            if (op_reg == OP_PROBE && resp.ok) begin
              found_reg[port_reg] <= 1'b1;
            end
            if (last_step) begin
              op_reg <= OP_PROBE;
              port_reg <= port_reg + 3'h1;
              state_reg <= (port_reg == `LAST_PORT) ? ST_DONE : ST_ISSUE;
            end else begin
              op_reg <= drive_op_t'(op_reg + 2'h1);
              state_reg <= ST_ISSUE;
            end
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Runs only for required drives and only with the selector at zero
  assign run_enable = (sel_reg == 4'h0) ? required_reg : 8'h00;
  assign required_flags = required_reg;

  // ********************************
  // Register read path
  // ********************************
  logic [31:0] status_word; // Found mask and test state
  logic [31:0] name_word; // Station name source and number

  assign status_word = {22'h0, state_reg == ST_DONE, busy, found_reg};
  assign name_word = {14'h0, station_name.mode, station_name.number};
  assign rd_mapped = (araddr[7:2] == `REG_RERUN_OFS >> 2) |
                     (araddr[7:2] == `REG_REQUIRED_OFS >> 2) |
                     (araddr[7:2] == `REG_STATUS_OFS >> 2) |
                     (araddr[7:2] == `REG_NAME_OFS >> 2);
  // Rerun register is write-only and reads as zero
  assign rd_value = (araddr[7:2] == `REG_REQUIRED_OFS >> 2) ? {24'h0, required_reg} :
                    (araddr[7:2] == `REG_STATUS_OFS >> 2) ? status_word :
                    (araddr[7:2] == `REG_NAME_OFS >> 2) ? name_word : 32'h0;

  // Read answer one cycle after the address is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rdata_reg <= 32'h0;
      rresp_reg <= `RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rdata_reg <= rd_value;
      rresp_reg <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ********************************
  // Serial-link lamp
  // ********************************
  logic [7:0] comm_ok; // Drive present and talking
  logic req_bad; // Required drive missing or silent
  logic req_derr; // Required drive reports an error
  logic [7:0] extra; // Drives present but not required
  logic extra_err; // Any unrequired drive reports an error
  logic [2:0] sel_idx; // Selected drive index
  logic sel_valid; // Selector points at a real port
  bicolor_t collective; // All-drive summary
  bicolor_t single; // Selected drive only
  bicolor_t serial_next; // Lamp value for the next cycle

  assign comm_ok = found_reg & ~comm_err;
  assign req_bad = |(required_reg & ~comm_ok);
  assign req_derr = |(required_reg & comm_ok & drive_err);
  assign extra = found_reg & ~required_reg;
  assign extra_err = |(extra & drive_err);
  assign sel_idx = 3'(sel_reg - 4'h1);
  assign sel_valid = (sel_reg != 4'h0) & (sel_reg <= 4'h8);

  // Summary, worst condition first
  always_comb begin
    if (busy) begin
      collective = '{red: ph5_reg, green: ~ph5_reg};
    end else if (state_reg != ST_DONE) begin
      collective = '{red: 1'b0, green: 1'b0};
    end else if (req_bad) begin
      collective = '{red: 1'b1, green: 1'b0};
    end else if (req_derr) begin
      collective = '{red: 1'b1, green: 1'b1};
    end else if (|extra && extra_err) begin
      collective = '{red: ph2_reg, green: ph2_reg};
    end else if (|extra) begin
      collective = '{red: 1'b0, green: ph2_reg};
    end else if (|found_reg) begin
      collective = '{red: 1'b0, green: 1'b1};
    end else begin
      // Nothing found and nothing required still counts as missing
      collective = '{red: 1'b1, green: 1'b0};
    end
  end

  // One drive picked by the selector
  always_comb begin
    if (!sel_valid || (!found_reg[sel_idx] && !required_reg[sel_idx])) begin
      single = '{red: 1'b0, green: 1'b0};
    end else if (!comm_ok[sel_idx]) begin
      single = '{red: 1'b1, green: 1'b0};
    end else if (drive_err[sel_idx]) begin
      single = '{red: 1'b1, green: 1'b1};
    end else begin
      single = '{red: 1'b0, green: 1'b1};
    end
  end

  assign serial_next = (sel_reg != 4'h0 && !busy) ? single : collective;

  // ********************************
  // Network lamps
  // ********************************
  logic [6:0] ident_cnt_reg; // Ticks left of identify flashing
  logic [1:0] link_next; // Link lamps for the next cycle
  logic [1:0] act_next; // Activity lamps for the next cycle
  logic net_fault_next; // Network fault lamp next value
  logic stat_fault_next; // Status fault lamp next value

  assign link_next = {second_network_port.link, first_network_port.link};
  assign act_next = {second_network_port.link & second_network_port.activity & ph10_reg,
                     first_network_port.link & first_network_port.activity & ph10_reg};
  assign net_fault_next = ~net_connected | (~data_exchange & ph2_reg);
  assign stat_fault_next = (watchdog_timeout | system_fault | diag_pending) |
                           ((ident_cnt_reg != 7'h0) & ph2_reg);

  // Identify request restarts the window; a request wins over the countdown
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ident_cnt_reg <= 7'h0;
    end else if (identify_req) begin
      ident_cnt_reg <= 7'(`IDENT_TICKS);
    end else if (tick && ident_cnt_reg != 7'h0) begin
      ident_cnt_reg <= ident_cnt_reg - 7'h1;
    end
  end

  // All lamps leave from flops so they never glitch
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_lamp <= 2'b00;
      activity_lamp <= 2'b00;
      network_fault_lamp <= 1'b1;
      status_fault_lamp <= 1'b0;
      serial_lamp <= '{red: 1'b0, green: 1'b0};
    end else begin
      link_lamp <= link_next;
      activity_lamp <= act_next;
      network_fault_lamp <= net_fault_next;
      status_fault_lamp <= stat_fault_next;
      serial_lamp <= serial_next;
    end
  end

  // ********************************
  // Station name
  // ********************************
  logic [1:0] settle_reg; // Waits for the synchronisers to fill
  logic name_taken_reg; // Switches sampled once after reset
  logic [15:0] sw_number; // Two BCD digits as a number

  assign sw_number = 16'(addr_sw_reg[7:4]) * 16'd10 + 16'(addr_sw_reg[3:0]);

  // Switches count only at power-up; later turning has no effect
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      settle_reg <= 2'h0;
      name_taken_reg <= 1'b0;
      station_name <= '{mode: NAME_CONTROLLER, number: 16'h0};
    end else if (!name_taken_reg) begin
      settle_reg <= settle_reg + 2'h1;
      if (settle_reg == `SETTLE_LAST) begin
        name_taken_reg <= 1'b1;
        if (addr_sw_reg != 8'h00) begin
          station_name <= '{mode: NAME_SWITCH, number: sw_number};
        end else if (nv_address != 16'h0) begin
          station_name <= '{mode: NAME_STORED, number: nv_address};
        end else begin
          station_name <= '{mode: NAME_CONTROLLER, number: 16'h0};
        end
      end
    end
  end
endmodule : drive_presence_status_indicator

// >>> verification/dpsi_asserts.sv
// Concurrent checks on the command link, lamps and run gate
`timescale 1ns/1ns
module dpsi_asserts (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command link
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire drive_status_pkg::drive_cmd_t cmd,
  // Network state and lamps
  input wire logic net_connected,
  input wire logic data_exchange,
  input wire logic watchdog_timeout,
  input wire drive_status_pkg::eth_port_t first_network_port,
  input wire logic [1:0] link_lamp,
  input wire logic [1:0] activity_lamp,
  input wire logic network_fault_lamp,
  input wire logic status_fault_lamp,
  // Run permission
  input wire logic [3:0] drive_selector_switch,
  input wire logic [7:0] run_enable,
  input wire logic [7:0] required_flags
);
  import drive_status_pkg::*;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // First request shortly after reset release
  sequence s_start;
    $rose(aresetn) ##[1:3] cmd_valid;
  endsequence
  a_auto_start: assert property ($rose(aresetn) |-> s_start)
    else $error("no request after reset");
  a_probe_first: assert property (s_start |-> cmd.op == OP_PROBE && cmd.port == 3'd0)
    else $error("first request is not a port 0 probe");
  a_addr_one: assert property (cmd_valid && cmd.op == OP_ADDR |-> cmd.data == 16'h0001)
    else $error("serial address is not 1");
  a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd))
    else $error("request dropped before taken");
  a_run_gate: assert property (
    run_enable == ($past(drive_selector_switch, 2) == 4'h0 ? required_flags : 8'h00))
    else $error("run allowed for unrequired drive");
  a_bus_off: assert property (!net_connected |=> network_fault_lamp)
    else $error("network fault lamp off while unconnected");
  a_bus_exch: assert property (net_connected && data_exchange |=> !network_fault_lamp)
    else $error("network fault lamp on during exchange");
  a_sf_on: assert property (watchdog_timeout |=> status_fault_lamp)
    else $error("status fault lamp off on watchdog");
  a_link_off: assert property (!first_network_port.link |=> !link_lamp[0])
    else $error("link lamp on without link");
  a_act_off: assert property (!first_network_port.link |=> !activity_lamp[0])
    else $error("activity lamp on without link");
endmodule : dpsi_asserts
bind drive_presence_status_indicator dpsi_asserts u_dpsi_asserts (.*);

// >>> verification/drive_engine_model.sv
// Serial-link engine model that answers drive commands
`timescale 1ns/1ns
module drive_engine_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Command link
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire drive_status_pkg::drive_cmd_t cmd,
  output drive_status_pkg::drive_resp_t resp,
  // Ports with a drive attached
  input wire logic [7:0] present
);
  import drive_status_pkg::*;
  logic [2:0] wait_reg;
  logic ok_reg;
  // Odd ports answer slowly; ready also stalls every other cycle
  always_ff @(posedge aclk) begin
    resp.valid <= 1'b0;
    resp.ok <= ~resp.ok;
    if (!aresetn) begin
      cmd_ready <= 1'b0;
      wait_reg <= 3'd0;
      resp <= '0;
    end else if (wait_reg != 3'd0) begin
      wait_reg <= wait_reg - 3'd1;
      if (wait_reg == 3'd1) begin
        resp.valid <= 1'b1;
        resp.ok <= ok_reg;
      end
    end else if (cmd_valid && cmd_ready) begin
      cmd_ready <= 1'b0;
      wait_reg <= cmd.port[0] ? 3'd4 : 3'd1;
      ok_reg <= (cmd.op != OP_PROBE) || present[cmd.port];
    end else begin
      cmd_ready <= ~cmd_ready;
    end
  end
endmodule : drive_engine_model

// >>> verification/tb.sv
// Self-checking bench for the drive presence and status block
`timescale 1ns/1ns
`include "drive_presence_status_indicator_consts.svh"
module tb;
  import drive_status_pkg::*;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid, cmd_valid, cmd_ready;
  logic [7:0] awaddr, araddr, nv_required, address_switch, present;
  logic [7:0] run_enable, required_flags, drive_err;
  logic [31:0] wdata, rdata, lfsr;
  logic [3:0] wstrb, drive_selector_switch;
  logic [1:0] bresp, rresp, link_lamp, activity_lamp;
  logic net_connected, data_exchange, watchdog_timeout, system_fault, diag_pending;
  logic network_fault_lamp, status_fault_lamp;
  drive_cmd_t cmd;
  drive_resp_t resp;
  baud_code_t [7:0] nv_baud;
  eth_port_t first_network_port, second_network_port;
  bicolor_t serial_lamp;
  station_name_t station_name;
  drive_cmd_t cq[$];
  int n_errors, num_checks;
  logic [7:0] cp [4] = '{8'h05, 8'h01, 8'h00, 8'h01};
  // Lamp summary {red any, red all, green any, green all}
  logic [3:0] cl [4] = '{4'b0010, 4'b0011, 4'b1100, 4'b1111};
  drive_presence_status_indicator #(.TICK_CYCLES(4)) u_drive_presence_status_indicator (.*,
    .identify_req(1'b0), .comm_err(8'h00), .nv_address(16'h0000));
  drive_engine_model u_drive_engine_model (.*);
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction : nx
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      n_errors++;
      $display("wrong value %s exp %0h seen %0h", nm, e, s);
    end
  endtask : chk
  // Expected command stream of one presence test
  task automatic plan(input logic [7:0] pr);
    logic [15:0] mt [4];
    mt = '{`MCT_BAUD0, `MCT_BAUD1, `MCT_BAUD2, `MCT_BAUD3};
    for (int p = 0; p < 8; p++) begin
      cq.push_back({OP_PROBE, 3'(p), 16'h0000});
      if (pr[p]) begin
        cq.push_back({OP_BAUD, 3'(p), 16'(nv_baud[p])});
        cq.push_back({OP_MCT, 3'(p), mt[nv_baud[p]]});
        cq.push_back({OP_ADDR, 3'(p), `DRIVE_LINK_ADDR});
      end
    end
  endtask : plan
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic da;
    logic dw;
    {da, dw} = 2'b00;
    {awaddr, wdata} <= {a, d};
    {awvalid, wvalid, bready} <= 3'b111;
    do begin
      @(negedge aclk);
      da = da | awready;
      dw = dw | wready;
      @(posedge aclk);
      {awvalid, wvalid} <= {!da, !dw};
    end while (!(da && dw));
    do @(negedge aclk); while (!bvalid);
    chk("bresp", bresp, er);
    @(posedge aclk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er);
    araddr <= a;
    {arvalid, rready} <= 2'b11;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    d = rdata;
    chk("rresp", rresp, er);
    @(posedge aclk);
  endtask : rd
  // Watch the serial lamp for 12 ticks
  task automatic lamp(input logic [3:0] e);
    logic [3:0] s;
    s = 4'b0101;
    repeat (48) begin
      @(negedge aclk);
      s = s | {serial_lamp.red, 1'b0, serial_lamp.green, 1'b0};
      s = s & {1'b1, serial_lamp.red, 1'b1, serial_lamp.green};
    end
    @(posedge aclk);
    chk("lamp", s, e);
  endtask : lamp
  task automatic stop_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test
  // Each taken command is compared with the oldest note
  always @(negedge aclk) begin
    if (cmd_valid && cmd_ready) begin
      chk("cmd", 32'(cmd), cq.size() ? 32'(cq.pop_front()) : '1);
    end
  end
  // Random network state
  always @(posedge aclk) begin
    lfsr <= nx(lfsr);
    {net_connected, data_exchange, watchdog_timeout, system_fault, diag_pending} <= lfsr[4:0];
    {first_network_port, second_network_port} <= lfsr[8:5];
  end
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  initial begin
    repeat (5000) @(posedge aclk);
    n_errors++;
    stop_test;
  end
  initial begin
    logic [31:0] d;
    lfsr = 32'h5960;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {drive_err, awaddr, araddr, wdata, drive_selector_switch, wstrb} = 64'hF;
    {net_connected, data_exchange, watchdog_timeout, system_fault, diag_pending} = '0;
    {first_network_port, second_network_port} = '0;
    {nv_baud, nv_required, address_switch, present} = {lfsr[23:8], 8'h01, 8'h42, cp[0]};
    plan(cp[0]);
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        {present, nv_baud, drive_err} <= {cp[k], lfsr[23:8], 7'h0, k == 3};
        @(posedge aclk);
        plan(cp[k]);
        wr(`REG_RERUN_OFS, `RERUN_CODE, `RESP_OKAY);
      end
      repeat (12) @(negedge aclk);
      chk("alt", serial_lamp.red ^ serial_lamp.green, 1);
      @(posedge aclk);
      d = '0;
      for (int i = 0; i < 60 && !d[`STAT_DONE_BIT]; i++) rd(`REG_STATUS_OFS, d, `RESP_OKAY);
      chk("found", d[7:0], cp[k]);
      chk("queue", cq.size(), 0);
      lamp(cl[k]);
      $display("test %0d done", k);
    end
    wr(`REG_REQUIRED_OFS, 32'h6, `RESP_OKAY);
    rd(`REG_REQUIRED_OFS, d, `RESP_OKAY);
    chk("req", d[7:0], 8'h06);
    chk("run", run_enable, 8'h06);
    drive_selector_switch <= 4'h2;
    repeat (4) @(posedge aclk);
    chk("run_sel", run_enable, 8'h00);
    rd(8'h40, d, `RESP_SLVERR);
    chk("name", station_name.mode, NAME_SWITCH);
    chk("num", station_name.number, 16'd42);
    $display("test 4 done");
    stop_test;
  end
endmodule : tb
